// *** msu_shift_unit.sv ***
// shift section: decode, byte register file, two-step word sequencing, flags
`timescale 1ns/100ps
module msu_shift_unit (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        mi_valid,
	input  wire logic [15:0] mi_word,
	output logic             mi_ready,
	output logic             done,
	input  wire logic        rf_wr_en,
	input  wire logic [3:0]  rf_wr_addr,
	input  wire logic [7:0]  rf_wr_data,
	input  wire logic [3:0]  rf_rd_addr,
	output logic [7:0]       rf_rd_data,
	output logic             sign_status,
	output logic             zero_status,
	output logic             half_carry_status,
	output logic             carry_out_status,
	output logic             cc_n,
	output logic             cc_z,
	output logic             cc_v,
	output logic             cc_c
);

	typedef struct packed {
		msu_pkg::msu_state_t               st;
		logic [msu_pkg::REG_CNT-1:0][7:0]  regs;
		logic [3:0]                        dst2;
		logic [3:0]                        src2;
		logic                              use_ext;
		logic                              ext_bit;
		logic                              right;
		logic                              upd_cc;
		logic [7:0]                        first_res;
		logic                              ready;
		logic                              done;
		logic [7:0]                        rd_data;
		logic                              sign;
		logic                              zero;
		logic                              half;
		logic                              cout;
		logic                              n;
		logic                              z;
		logic                              v;
		logic                              c;
	} msu_regs_t;

	msu_regs_t q_reg;
	msu_regs_t q_next;

	msu_shift_if sh ();

	msu_shift_core u_core (
		.sh (sh.core)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_shift(input logic [6:0] op);
		return op == msu_pkg::OPC_SHL_BYTE_CARRY || op == msu_pkg::OPC_SHL_WORD_CARRY ||
			op == msu_pkg::OPC_SHL_BYTE || op == msu_pkg::OPC_SHL_WORD ||
			op == msu_pkg::OPC_SHR_BYTE_CARRY || op == msu_pkg::OPC_SHR_WORD_CARRY ||
			op == msu_pkg::OPC_SHR_BYTE || op == msu_pkg::OPC_SHR_WORD;
	endfunction

	// partner byte of a pair: next for left words, previous for right words
	function automatic logic [3:0] pair_idx(input logic [3:0] idx, input logic right);
		return right ? 4'(idx - 4'h1) : 4'(idx + 4'h1);
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [6:0]  op;
	logic        dec_right;
	logic        dec_word;
	logic        dec_carry;
	logic        dec_upd;
	logic [3:0]  a_idx;
	logic [3:0]  b_idx;
	logic [15:0] w16;

	always_comb begin
		op        = mi_word[msu_pkg::OP_HI:msu_pkg::OP_LO];
		dec_right = mi_word[msu_pkg::RIGHT_BIT];
		dec_word  = mi_word[msu_pkg::WORD_BIT];
		dec_carry = ~mi_word[msu_pkg::PLAIN_BIT];
		dec_upd   = mi_word[msu_pkg::CC_BIT];
		a_idx     = mi_word[msu_pkg::AFLD_HI:msu_pkg::AFLD_LO];
		b_idx     = mi_word[msu_pkg::BFLD_HI:msu_pkg::BFLD_LO];
		w16       = 16'h0000;

		q_next         = q_reg;
		q_next.done    = 1'b0;
		q_next.rd_data = q_reg.regs[rf_rd_addr];
		if (rf_wr_en) begin
			q_next.regs[rf_wr_addr] = rf_wr_data;
		end

		// first step: operand is always the byte named by the source field
		sh.dir_right = dec_right;
		sh.operand   = q_reg.regs[b_idx];
		sh.fill      = dec_carry & q_reg.c;

		unique case (q_reg.st)
			msu_pkg::MSU_IDLE: begin
				if (mi_valid && is_shift(op)) begin
					// only the destination byte is written
					q_next.regs[a_idx] = sh.result;
					q_next.sign = sh.result[7];
					q_next.zero = sh.result == 8'h00;
					q_next.cout = sh.shifted_out;
					if (!dec_right) begin
						q_next.half = sh.half_carry;
					end
					if (dec_word) begin
						// second byte follows next cycle, carry held in status
						q_next.st        = msu_pkg::MSU_SECOND;
						q_next.ready     = 1'b0;
						q_next.dst2      = pair_idx(a_idx, dec_right);
						q_next.src2      = pair_idx(b_idx, dec_right);
						q_next.use_ext   = ~dec_right & b_idx[0];
						q_next.ext_bit   = q_reg.regs[b_idx][7];
						q_next.right     = dec_right;
						q_next.upd_cc    = dec_upd;
						q_next.first_res = sh.result;
					end else begin
						q_next.done = 1'b1;
						if (dec_upd) begin
							q_next.n = sh.result[7];
							q_next.z = sh.result == 8'h00;
							q_next.c = sh.shifted_out;
							if (!dec_right) begin
								q_next.v = sh.result[7] ^ sh.shifted_out;
							end
						end
					end
				end
			end
			msu_pkg::MSU_SECOND: begin
				sh.dir_right = q_reg.right;
				sh.operand   = q_reg.use_ext ? {8{q_reg.ext_bit}} : q_reg.regs[q_reg.src2];
				sh.fill      = q_reg.cout;
				q_next.regs[q_reg.dst2] = sh.result;
				w16 = q_reg.right ? {q_reg.first_res, sh.result} : {sh.result, q_reg.first_res};
				q_next.sign = w16[15];
				q_next.zero = w16 == 16'h0000;
				q_next.cout = sh.shifted_out;
				if (!q_reg.right) begin
					q_next.half = sh.half_carry;
				end
				if (q_reg.upd_cc) begin
					q_next.n = w16[15];
					q_next.z = w16 == 16'h0000;
					q_next.c = sh.shifted_out;
					if (!q_reg.right) begin
						q_next.v = w16[15] ^ sh.shifted_out;
					end
				end
				q_next.st    = msu_pkg::MSU_IDLE;
				q_next.ready = 1'b1;
				q_next.done  = 1'b1;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_reg         <= '0;
			q_reg.st      <= msu_pkg::MSU_IDLE;
			q_reg.regs    <= {msu_pkg::REG_CNT{msu_pkg::REG_RESET}};
			q_reg.ready   <= 1'b1;
			q_reg.sign    <= msu_pkg::FLAG_RESET;
			q_reg.zero    <= msu_pkg::FLAG_RESET;
			q_reg.half    <= msu_pkg::FLAG_RESET;
			q_reg.cout    <= msu_pkg::FLAG_RESET;
			q_reg.n       <= msu_pkg::FLAG_RESET;
			q_reg.z       <= msu_pkg::FLAG_RESET;
			q_reg.v       <= msu_pkg::FLAG_RESET;
			q_reg.c       <= msu_pkg::FLAG_RESET;
		end else begin
			q_reg <= q_next;
		end
	end

	assign mi_ready          = q_reg.ready;
	assign done              = q_reg.done;
	assign rf_rd_data        = q_reg.rd_data;
	assign sign_status       = q_reg.sign;
	assign zero_status       = q_reg.zero;
	assign half_carry_status = q_reg.half;
	assign carry_out_status  = q_reg.cout;
	assign cc_n              = q_reg.n;
	assign cc_z              = q_reg.z;
	assign cc_v              = q_reg.v;
	assign cc_c              = q_reg.c;

endmodule

// *** msu_pkg.sv ***
// constants and types for the shift section of the byte-wide alu
//
// Overview of operation
// - left byte with carry: source shifted left, old carry fills bit 0
// - every left shift: half-carry status takes carry out of bit 3 of a byte, of bit 11 of a word
// - plain left word: pair shifted left in two microcycles, carry gets top bit
// - left word with odd source: sign-extend that byte, then shift the word
// - left word with carry: prior carry into bit 0, carry gets top bit
// - flag-updating left shifts: overflow on sign change, N and Z from result
// - plain right byte: carry gets low bit, half-carry and overflow unchanged
// - right byte with carry: prior carry fills vacated top bit
// - plain right word: pair shifted right, carry gets low bit
// - right word with carry: prior carry fills vacated top bit
// - right word shifts start at high byte; both fields name odd bytes
// - carry-out status follows the bit shifted off on every shift
// - source register never altered; only destination byte or pair written
// - status flags update on every shift (half-carry on left shifts only); condition codes only when CC_BIT (bit 8) is set
// - byte shifts: sign status is bit 7, zero status when byte is zero
// - word shifts: sign and zero status judged on full 16-bit result
// - word shifts run as two byte steps, carry passed through status flags
// - CC_BIT (bit 8) set below the opcode also updates the condition codes
package msu_pkg;

	localparam int DATA_W   = 8;
	localparam int REG_CNT  = 16;
	localparam int IDX_W    = 4;
	localparam int MI_W     = 16;

	// microinstruction field positions
	localparam int OP_HI    = 15;
	localparam int OP_LO    = 9;
	localparam int CC_BIT   = 8;
	localparam int RIGHT_BIT = 14;
	localparam int PLAIN_BIT = 10;
	localparam int WORD_BIT = 9;
	localparam int BFLD_HI  = 7;
	localparam int BFLD_LO  = 4;
	localparam int AFLD_HI  = 3;
	localparam int AFLD_LO  = 0;

	// seven-bit opcodes, bits 15..9
	localparam logic [6:0] OPC_SHL_BYTE_CARRY = 7'h44;
	localparam logic [6:0] OPC_SHL_WORD_CARRY = 7'h45;
	localparam logic [6:0] OPC_SHL_BYTE       = 7'h46;
	localparam logic [6:0] OPC_SHL_WORD       = 7'h47;
	localparam logic [6:0] OPC_SHR_BYTE_CARRY = 7'h6c;
	localparam logic [6:0] OPC_SHR_WORD_CARRY = 7'h6d;
	localparam logic [6:0] OPC_SHR_BYTE       = 7'h6e;
	localparam logic [6:0] OPC_SHR_WORD       = 7'h6f;

	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic       FLAG_RESET = 1'b0;

	typedef enum logic {
		MSU_IDLE   = 1'b0,
		MSU_SECOND = 1'b1
	} msu_state_t;

endpackage

// *** msu_shift_if.sv ***
// one-byte shift step between the sequencing logic and the shifter
`timescale 1ns/100ps
interface msu_shift_if;
	logic       dir_right;
	logic [7:0] operand;
	logic       fill;
	logic [7:0] result;
	logic       shifted_out;
	logic       half_carry;

	modport core (input dir_right, input operand, input fill,
		output result, output shifted_out, output half_carry);
	modport user (output dir_right, output operand, output fill,
		input result, input shifted_out, input half_carry);
endinterface

// *** msu_shift_core.sv ***
// combinational one-byte shifter
`timescale 1ns/100ps
module msu_shift_core (
	msu_shift_if.core sh
);
	always_comb begin
		if (sh.dir_right) begin
			sh.result      = {sh.fill, sh.operand[7:1]};
			sh.shifted_out = sh.operand[0];
		end else begin
			sh.result      = {sh.operand[6:0], sh.fill};
			sh.shifted_out = sh.operand[7];
		end
		// carry out of bit 3 lands in bit 4 on a left shift
		sh.half_carry = sh.operand[3];
	end
endmodule

// *** msu_shift_unit_props.sv ***
// port assertions for the shift section
`timescale 1ns/100ps
module msu_shift_unit_props (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        mi_valid,
	input wire logic [15:0] mi_word,
	input wire logic        mi_ready,
	input wire logic        done,
	input wire logic        sign_status,
	input wire logic        zero_status,
	input wire logic        half_carry_status,
	input wire logic        carry_out_status,
	input wire logic        cc_n,
	input wire logic        cc_z,
	input wire logic        cc_v,
	input wire logic        cc_c
);
	wire       acc = mi_valid && mi_ready && mi_word[15:11] inside {5'h11, 5'h1b};
	wire       wd  = mi_word[9];
	wire       rt  = mi_word[14];
	wire       upd = mi_word[8];
	wire [3:0] cc  = {cc_n, cc_z, cc_v, cc_c};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_byte_one_cycle: assert property (acc && !wd |=> done && mi_ready)
		else $error("byte shift late");
	chk_word_two_cycles: assert property (acc && wd |=> !mi_ready && !done ##1 done && mi_ready)
		else $error("word shift timing wrong");
	chk_cc_hold: assert property (acc && !upd |=> $stable(cc))
		else $error("condition codes changed");
	chk_cc_follow: assert property (acc && upd && !wd |=>
		cc_n == sign_status && cc_z == zero_status && cc_c == carry_out_status)
		else $error("condition codes differ from status");
	chk_left_overflow: assert property (acc && upd && !wd && !rt |=> cc_v == (sign_status ^ carry_out_status))
		else $error("overflow wrong");
	chk_right_keeps: assert property (acc && rt && !wd |=> $stable(half_carry_status) && $stable(cc_v))
		else $error("right shift touched half carry or overflow");
	chk_zero_sign: assert property (done && zero_status |-> !sign_status)
		else $error("zero result with sign set");
	chk_reset_idle: assert property (disable iff (1'b0) !rst_n |=> mi_ready && !done && cc == 4'h0)
		else $error("reset state wrong");
endmodule
bind msu_shift_unit msu_shift_unit_props u_props (.*);

// *** msu_seq_model.sv ***
// issues microinstructions and holds each until the shifter takes it
`timescale 1ns/100ps
module msu_seq_model (
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic [15:0] word_in,
	input  wire logic        mi_ready,
	output logic             mi_valid,
	output logic [15:0]      mi_word
);
	initial begin
		mi_valid = 1'b0;
		mi_word  = 16'h0000;
	end
	always @(posedge clk) begin
		if (mi_valid && mi_ready) begin
			mi_valid <= 1'b0;
			// scrambled so a released word is never mistaken for a live one
			mi_word  <= ~mi_word;
		end else if (start) begin
			mi_valid <= 1'b1;
			mi_word  <= word_in;
		end
	end
endmodule

// *** msu_shift_unit_tb.sv ***
// randomised self-checking bench for the shift section
`timescale 1ns/100ps
module msu_shift_unit_tb;
	logic        clk, rst_n, start, mi_valid, mi_ready, done, rf_wr_en;
	logic        sign_status, zero_status, half_carry_status, carry_out_status, cc_n, cc_z, cc_v, cc_c;
	logic [15:0] word_in, mi_word;
	logic [3:0]  rf_wr_addr, rf_rd_addr;
	logic [7:0]  rf_wr_data, rf_rd_data, ef;
	logic [7:0]  mem [16];
	int          seed, fail_count, comparisons, i;
	wire  [8:0]  flags = {done, sign_status, zero_status, half_carry_status, carry_out_status,
		cc_n, cc_z, cc_v, cc_c};

	msu_seq_model u_msu_seq_model (.*);
	msu_shift_unit u_msu_shift_unit (.*);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----
	// bench tasks
	// ----
	task automatic check(input logic [8:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		{rf_wr_en, rf_wr_addr, rf_wr_data} <= {1'b1, a, d};
		mem[a] = d;
		@(posedge clk);
		rf_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		rf_rd_addr <= a;
		@(posedge clk);
		#1;
		check({1'b0, rf_rd_data}, {1'b0, mem[a]});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// k: bit2 right, bit1 plain, bit0 word
	task automatic run(input logic [2:0] k, input logic upd, input logic [2:0] bs, as);
		logic [6:0]  op;
		logic [3:0]  a, b;
		logic [15:0] w, r;
		logic [7:0]  rb;
		logic        out, sg, zr;
		int          n;
		op = {1'b1, k[2], 1'b0, k[2], 1'b1, k[1:0]};
		b = {1'b0, bs[2:1], bs[0] | (k[2] & k[0])};
		a = {1'b1, as[2:1], k[0] ? k[2] : as[0]};
		// byte operand doubled so both directions index the same bits as a word
		if (!k[0]) w = {mem[b], mem[b]};
		else if (k[2]) w = {mem[b], mem[b - 4'h1]};
		else w = {b[0] ? {8{mem[b][7]}} : mem[b + 4'h1], mem[b]};
		r = k[2] ? {~k[1] & ef[0], w[15:1]} : {w[14:0], ~k[1] & ef[0]};
		rb = k[2] ? r[15:8] : r[7:0];
		out = k[2] ? w[0] : w[15];
		sg = k[0] ? r[15] : rb[7];
		zr = k[0] ? r == 16'h0000 : rb == 8'h00;
		ef[7:4] = {sg, zr, k[2] ? ef[5] : w[11], out};
		if (upd) ef[3:0] = {sg, zr, k[2] ? ef[1] : sg ^ out, out};
		@(posedge clk);
		word_in <= {op, upd, b, a};
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(flags, {1'b1, ef});
		if (!k[0]) mem[a] = rb;
		else if (k[2]) {mem[a], mem[a - 4'h1]} = r;
		else {mem[a + 4'h1], mem[a]} = r;
		rd(a);
		rd(k[2] ? a - 4'h1 : a + 4'h1);
		rd(b);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		seed = 88417;
		{rst_n, start, rf_wr_en, word_in, rf_wr_addr, rf_wr_data, rf_rd_addr} = '0;
		ef = 8'h00;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 16; i++) wr(i[3:0], 8'($random(seed)));
		wr(4'h3, 8'h88);
		for (i = 0; i < 16; i++) run(i[3:1], i[0], 3'h3, 3'h1);
		$display("directed shifts done");
		for (i = 0; i < 300; i++) begin
			wr({1'b0, i[2:0]}, 8'($random(seed)));
			run(3'($random(seed)), 1'($random(seed)), 3'($random(seed)), 3'($random(seed)));
		end
		$display("random shifts done");
		tally_and_finish;
	end
	initial begin
		#100000;
		fail_count++;
		tally_and_finish;
	end
endmodule
